// ===== design/fsr_map.svh
// Bit positions, opcodes, reset values and timing counts of the flash status registers
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
// Status register one
`define FSR_BUSY_BIT      0
`define FSR_WLATCH_BIT    1
`define FSR_BP0_BIT       2
`define FSR_TOPBOT_BIT    5
`define FSR_SECG_BIT      6
`define FSR_SPM_BIT       7
// Status register two
`define FSR_LOCK_BIT      0
`define FSR_QUAD_BIT      1
`define FSR_SL1_BIT       3
`define FSR_COMPL_BIT     6
`define FSR_SUSPF_BIT     7
// Status register three
`define FSR_SCHEME_BIT    2
`define FSR_DRV_LO_BIT    5
`define FSR_HRS_BIT       7
// Reset values
`define FSR_REG1_RST      8'h00
`define FSR_REG2_RST      8'h00
`define FSR_REG3_RST      8'h60
// Instruction codes
`define FSR_OP_WREN       8'h06
`define FSR_OP_WRDI       8'h04
`define FSR_OP_RDSR1      8'h05
`define FSR_OP_RDSR2      8'h35
`define FSR_OP_RDSR3      8'h15
`define FSR_OP_WRSR1      8'h01
`define FSR_OP_WRSR2      8'h31
`define FSR_OP_WRSR3      8'h11
`define FSR_OP_PP         8'h02
`define FSR_OP_QPP        8'h32
`define FSR_OP_SE         8'h20
`define FSR_OP_BE32       8'h52
`define FSR_OP_BE64       8'hD8
`define FSR_OP_CE         8'hC7
`define FSR_OP_SECE       8'h44
`define FSR_OP_SECP       8'h42
`define FSR_OP_SUSP       8'h75
`define FSR_OP_RESU       8'h7A
`define FSR_OP_FOURW      8'h38
`define FSR_OP_PFX1       8'hAA
`define FSR_OP_PFX2       8'h55
// Internal operation time in system clock cycles
`define FSR_BUSY_CYC      16'd0400
`endif

// ===== design/fsr_pkg.sv
// Types of the flash status register block
package fsr_pkg;
  typedef enum logic [3:0] {
    FSR_IDLE = 4'b0001,
    FSR_OPC  = 4'b0010,
    FSR_DATA = 4'b0100,
    FSR_READ = 4'b1000
  } fsr_state_t;
endpackage

// ===== design/fsr_regs.sv
// Serial flash status and configuration registers behind the serial bus
`timescale 1ns/1ps
`include "fsr_map.svh"
// What this block does
// - Busy bit zero stays high through program, erase, register write or security operation.
// - While busy, only status reads and suspend instructions are obeyed.
// - Busy clears to zero when the internal operation completes.
// - Write enable instruction sets the write enable latch at bit one.
// - Latch clears at reset, write disable, program, erase, status or security write.
// - Block protect bits four to two are writable, default zero.
// - Top bottom select picks top at zero, bottom at one, default zero.
// - Sector granularity picks 4KB sectors at one, 64KB blocks at zero.
// - Complement protect at bit fourteen inverts the protected region.
// - Protect mode bit seven and lock bit eight select register protection scheme.
// - Both zero: status writes need the latch set, pin ignored.
// - Lock zero, mode one, quad enable zero: writes refused while protect pin low.
// - Lock one blocks all status writes until power cycle clears it.
// - Lock set after prefix bytes AAh 55h protects registers until reset.
// - Suspend flag bit fifteen sets on 75h, clears on 7Ah or reset.
// - Security locks bits thirteen to eleven are one-time, cleared only by reset.
// - Quad enable bit nine turns protect and pause pins into data lines.
// - Enter four-wire mode 38h ignored unless quad enable is one.
// - In four-wire mode quad enable stays one despite status writes.
// - Scheme select zero uses range bits, one uses block locks defaulting to one.
// - Drive strength field 00 100%, 01 75%, 10 50%, 11 25% default.
// - Quad enable zero: shared pin pauses at select zero, clears at one.
module fsr_regs (
  // System
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Serial bus pins
  input  wire logic       spi_clk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_di,
  input  wire logic       wp_pin_n,
  output logic            spi_do,
  output logic            spi_do_oe,
  // Decoded configuration
  output logic            busy,
  output logic            four_wire_command_mode,
  output logic            quad_pins_en,
  output logic            pause_pin_en,
  output logic            pin_clear_en,
  output logic            range_prot_en,
  output logic            block_lock_init,
  output logic [1:0]      drive_level,
  output logic [23:0]     status_word
);
  // ===========================================================
  // Pin synchronisers
  logic [1:0] clk_s_r, cs_s_r, di_s_r, wp_s_r;
  logic       clk_d_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_s_r <= 2'h0;
      cs_s_r  <= 2'h3;
      di_s_r  <= 2'h0;
      wp_s_r  <= 2'h3;
      clk_d_r <= 1'b0;
    end else begin
      clk_s_r <= {clk_s_r[0], spi_clk};
      cs_s_r  <= {cs_s_r[0], spi_cs_n};
      di_s_r  <= {di_s_r[0], spi_di};
      wp_s_r  <= {wp_s_r[0], wp_pin_n};
      clk_d_r <= clk_s_r[1];
    end
  end
  wire rise = clk_s_r[1] & ~clk_d_r;
  wire fall = ~clk_s_r[1] & clk_d_r;
  wire sel  = ~cs_s_r[1];
  wire wp_hi = wp_s_r[1];

  // Opcodes that start an internal operation and drop the latch
  function automatic logic is_prog_op(input logic [7:0] op);
    is_prog_op = (op == `FSR_OP_PP) || (op == `FSR_OP_QPP) || (op == `FSR_OP_SE) ||
                 (op == `FSR_OP_BE32) || (op == `FSR_OP_BE64) || (op == `FSR_OP_CE) ||
                 (op == `FSR_OP_SECE) || (op == `FSR_OP_SECP);
  endfunction
  function automatic logic is_wrsr(input logic [7:0] op);
    is_wrsr = (op == `FSR_OP_WRSR1) || (op == `FSR_OP_WRSR2) || (op == `FSR_OP_WRSR3);
  endfunction

  // ===========================================================
  // State
  fsr_pkg::fsr_state_t st_r, st_nxt;
  logic [7:0]  sh_r, sh_nxt, op_r, op_nxt;
  logic [2:0]  bc_r, bc_nxt;
  logic [7:0]  sr1_r, sr1_nxt, sr2_r, sr2_nxt, sr3_r, sr3_nxt;
  logic [15:0] bt_r, bt_nxt;
  logic        otp_r, otp_nxt, pfx1_r, pfx1_nxt, pfx_r, pfx_nxt, fw_r, fw_nxt;
  logic        do_r, do_nxt, oe_r, oe_nxt;
  logic [7:0]  rd_v, wr_v, ob;
  logic        sr_ok, quad_new;

  // Next-state logic of the serial engine and the registers
  always_comb begin
    st_nxt = st_r; sh_nxt = sh_r; op_nxt = op_r; bc_nxt = bc_r;
    sr1_nxt = sr1_r; sr2_nxt = sr2_r; sr3_nxt = sr3_r;
    bt_nxt = bt_r; otp_nxt = otp_r; pfx1_nxt = pfx1_r; pfx_nxt = pfx_r;
    fw_nxt = fw_r; do_nxt = do_r; oe_nxt = oe_r;
    wr_v = {sh_r[6:0], di_s_r[1]};
    ob = 8'h00;
    quad_new = 1'b0;
    // Write permission from lock, mode and pin
    sr_ok = sr1_r[`FSR_WLATCH_BIT] & ~sr2_r[`FSR_LOCK_BIT] & ~otp_r &
            (~sr1_r[`FSR_SPM_BIT] | wp_hi | sr2_r[`FSR_QUAD_BIT]);
    case (op_r)
      `FSR_OP_RDSR2: rd_v = sr2_r;
      `FSR_OP_RDSR3: rd_v = sr3_r;
      default:       rd_v = sr1_r;
    endcase
    // Internal operation timer
    if (bt_r != 16'd0) begin
      bt_nxt = bt_r - 16'd1;
      if (bt_r == 16'd1)
        sr1_nxt[`FSR_BUSY_BIT] = 1'b0;
    end
    if (!sel) begin
      st_nxt = fsr_pkg::FSR_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        fsr_pkg::FSR_IDLE: begin
          st_nxt = fsr_pkg::FSR_OPC;
          bc_nxt = 3'd0;
        end
        fsr_pkg::FSR_OPC: if (rise) begin
          sh_nxt = wr_v;
          bc_nxt = bc_r + 3'd1;
          if (bc_r == 3'd7) begin
            op_nxt = wr_v;
            st_nxt = fsr_pkg::FSR_IDLE;
            // Busy filter: only reads and suspend pass
            if (sr1_r[`FSR_BUSY_BIT] && wr_v != `FSR_OP_SUSP && wr_v != `FSR_OP_RDSR1 &&
                wr_v != `FSR_OP_RDSR2 && wr_v != `FSR_OP_RDSR3) begin
              st_nxt = fsr_pkg::FSR_DATA;
              op_nxt = 8'hFF;
            end else begin
              pfx1_nxt = (wr_v == `FSR_OP_PFX1);
              // Prefix stays armed through the register two write that follows it
              if (wr_v != `FSR_OP_PFX2 && wr_v != `FSR_OP_WRSR2)
                pfx_nxt = 1'b0;
              else if (pfx1_r)
                pfx_nxt = 1'b1;
              case (wr_v)
                `FSR_OP_WREN: sr1_nxt[`FSR_WLATCH_BIT] = 1'b1;
                `FSR_OP_WRDI: sr1_nxt[`FSR_WLATCH_BIT] = 1'b0;
                `FSR_OP_SUSP: sr2_nxt[`FSR_SUSPF_BIT] = 1'b1;
                `FSR_OP_RESU: sr2_nxt[`FSR_SUSPF_BIT] = 1'b0;
                `FSR_OP_FOURW: fw_nxt = sr2_r[`FSR_QUAD_BIT];
                `FSR_OP_RDSR1, `FSR_OP_RDSR2, `FSR_OP_RDSR3: st_nxt = fsr_pkg::FSR_READ;
                default: begin
                  if (is_wrsr(wr_v))
                    st_nxt = fsr_pkg::FSR_DATA;
                  if (is_prog_op(wr_v) && sr1_r[`FSR_WLATCH_BIT]) begin
                    sr1_nxt[`FSR_WLATCH_BIT] = 1'b0;
                    sr1_nxt[`FSR_BUSY_BIT] = 1'b1;
                    bt_nxt = `FSR_BUSY_CYC;
                  end
                end
              endcase
              if (wr_v == `FSR_OP_PFX1 || wr_v == `FSR_OP_PFX2)
                st_nxt = fsr_pkg::FSR_IDLE;
            end
            if (st_nxt == fsr_pkg::FSR_IDLE)
              st_nxt = fsr_pkg::FSR_DATA;
          end
        end
        fsr_pkg::FSR_DATA: if (rise) begin
          sh_nxt = wr_v;
          bc_nxt = bc_r + 3'd1;
          if (bc_r == 3'd7 && is_wrsr(op_r)) begin
            op_nxt = 8'hFF;
            if (sr_ok) begin
              sr1_nxt[`FSR_WLATCH_BIT] = 1'b0;
              sr1_nxt[`FSR_BUSY_BIT] = 1'b1;
              bt_nxt = `FSR_BUSY_CYC;
              case (op_r)
                `FSR_OP_WRSR1: sr1_nxt[7:2] = wr_v[7:2];
                `FSR_OP_WRSR2: begin
                  quad_new = wr_v[`FSR_QUAD_BIT] | (fw_r & sr2_r[`FSR_QUAD_BIT]);
                  sr2_nxt = {sr2_r[7], wr_v[6], sr2_r[5:3] | wr_v[5:3], 1'b0,
                             quad_new, wr_v[0]};
                  if (wr_v[`FSR_LOCK_BIT] && pfx_r)
                    otp_nxt = 1'b1;
                end
                default: sr3_nxt = {wr_v[7], wr_v[6:5], 2'b00, wr_v[2], 2'b00};
              endcase
            end
          end
        end
        fsr_pkg::FSR_READ: if (fall) begin
          ob = rd_v;
          do_nxt = ob[3'd7 - bc_r];
          oe_nxt = 1'b1;
          bc_nxt = bc_r + 3'd1;
        end
        default: st_nxt = fsr_pkg::FSR_IDLE;
      endcase
    end
  end

  // Registers of the block
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= fsr_pkg::FSR_IDLE;
      sh_r <= 8'h00; op_r <= 8'hFF; bc_r <= 3'd0;
      sr1_r <= `FSR_REG1_RST; sr2_r <= `FSR_REG2_RST; sr3_r <= `FSR_REG3_RST;
      bt_r <= 16'd0; otp_r <= 1'b0; pfx1_r <= 1'b0; pfx_r <= 1'b0; fw_r <= 1'b0;
      do_r <= 1'b0; oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt; sh_r <= sh_nxt; op_r <= op_nxt; bc_r <= bc_nxt;
      sr1_r <= sr1_nxt; sr2_r <= sr2_nxt; sr3_r <= sr3_nxt;
      bt_r <= bt_nxt; otp_r <= otp_nxt; pfx1_r <= pfx1_nxt; pfx_r <= pfx_nxt; fw_r <= fw_nxt;
      do_r <= do_nxt; oe_r <= oe_nxt;
    end
  end

  // ===========================================================
  // Decoded configuration outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0; four_wire_command_mode <= 1'b0; quad_pins_en <= 1'b0;
      pause_pin_en <= 1'b0; pin_clear_en <= 1'b0; range_prot_en <= 1'b0;
      block_lock_init <= 1'b0; drive_level <= 2'h0; status_word <= 24'h000000;
      spi_do <= 1'b0; spi_do_oe <= 1'b0;
    end else begin
      busy <= sr1_r[`FSR_BUSY_BIT];
      four_wire_command_mode <= fw_r;
      quad_pins_en <= sr2_r[`FSR_QUAD_BIT];
      pause_pin_en <= ~sr2_r[`FSR_QUAD_BIT] & ~sr3_r[`FSR_HRS_BIT];
      pin_clear_en <= ~sr2_r[`FSR_QUAD_BIT] & sr3_r[`FSR_HRS_BIT];
      range_prot_en <= ~sr3_r[`FSR_SCHEME_BIT];
      block_lock_init <= sr3_r[`FSR_SCHEME_BIT];
      drive_level <= sr3_r[6:5];
      status_word <= {sr3_r, sr2_r, sr1_r};
      spi_do <= do_r;
      spi_do_oe <= oe_r;
    end
  end

  // ===========================================================
  // Checks
  property p_busy_clear;
    @(posedge clock) disable iff (!rst_n) (bt_r == 16'd1) |=> !sr1_r[`FSR_BUSY_BIT];
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");
  property p_busy_hold;
    @(posedge clock) disable iff (!rst_n) (bt_r > 16'd1) |=> sr1_r[`FSR_BUSY_BIT];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_quad_fw;
    @(posedge clock) disable iff (!rst_n) $rose(fw_r) |-> $past(sr2_r[`FSR_QUAD_BIT]);
  endproperty
  a_quad_fw: assert property (p_quad_fw) else $error("four wire mode without quad enable");
  property p_quad_stay;
    @(posedge clock) disable iff (!rst_n) (fw_r && sr2_r[`FSR_QUAD_BIT]) |=> sr2_r[`FSR_QUAD_BIT];
  endproperty
  a_quad_stay: assert property (p_quad_stay) else $error("quad enable cleared in four wire mode");
  property p_lock_block;
    @(posedge clock) disable iff (!rst_n) sr2_r[`FSR_LOCK_BIT] |=> $stable(sr1_r[7:2]);
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("write while locked");
  property p_otp_keep;
    @(posedge clock) disable iff (!rst_n) $past(sr2_r[5:3]) == ($past(sr2_r[5:3]) & sr2_r[5:3]);
  endproperty
  a_otp_keep: assert property (p_otp_keep) else $error("security lock cleared");
  property p_hw_prot;
    @(posedge clock) disable iff (!rst_n)
      (sr1_r[`FSR_SPM_BIT] && !wp_hi && !sr2_r[`FSR_QUAD_BIT]) |=>
        !$rose(sr1_r[`FSR_BUSY_BIT]) || bt_r != `FSR_BUSY_CYC || !is_wrsr($past(op_r));
  endproperty
  a_hw_prot: assert property (p_hw_prot) else $error("write with protect pin low");
  property p_pins;
    @(posedge clock) disable iff (!rst_n) !(pause_pin_en && quad_pins_en) && !(pin_clear_en && pause_pin_en);
  endproperty
  a_pins: assert property (p_pins) else $error("pin roles overlap");
  property p_wel_op;
    @(posedge clock) disable iff (!rst_n) $rose(sr1_r[`FSR_BUSY_BIT]) |-> !sr1_r[`FSR_WLATCH_BIT];
  endproperty
  a_wel_op: assert property (p_wel_op) else $error("latch left set after operation");
  c_busy: cover property (@(posedge clock) disable iff (!rst_n) $fell(sr1_r[`FSR_BUSY_BIT]));
  c_fw: cover property (@(posedge clock) disable iff (!rst_n) $rose(fw_r));
  c_suspend: cover property (@(posedge clock) disable iff (!rst_n) $rose(sr2_r[`FSR_SUSPF_BIT]));
  c_otp: cover property (@(posedge clock) disable iff (!rst_n) $rose(otp_r));
endmodule

// ===== dv/fsr_host.sv
// Serial bus host model that sends frames to the status register block
`timescale 1ns/1ps
module fsr_host (
  // Serial bus
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_di,
  input  wire logic spi_do
);
  // Bus parked: clock low, device deselected
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_di = 1'b0;
  end
  // One frame: opcode, then a data byte out or a byte read back, MSB first
  task automatic frame(input logic [7:0] opc, input logic [7:0] dat, input int nb, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {opc, dat};
    rd = 8'h00;
    // Step off the system clock edges so no pin moves as it is sampled
    #1;
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 * nb; i++) begin
      #62.5 spi_clk = 1'b0;
      spi_di = sh[15];
      sh = sh << 1;
      #62.5 spi_clk = 1'b1;
      rd = {rd[6:0], spi_do};
    end
    #62.5 spi_clk = 1'b0;
    #62.5 spi_cs_n = 1'b1;
    // Released data line shows the inverse so a stale bit is never trusted
    spi_di = ~spi_di;
    #250;
  endtask
endmodule

// ===== dv/fsr_regs_bench.sv
// Bench for the flash status registers against a reference model
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_regs_bench;
  // Pins and outputs
  logic        clock, rst_n, wp_pin_n, spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe;
  logic        busy, four_wire_command_mode, quad_pins_en, pause_pin_en, pin_clear_en;
  logic        range_prot_en, block_lock_init;
  logic [1:0]  drive_level;
  logic [23:0] status_word;
  // Reference model state and counters
  logic [23:0] m;
  logic        fw;
  logic [7:0]  r;
  int          err_total, checks_done;

  fsr_regs u_fsr_regs (.clock(clock), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_di(spi_di), .wp_pin_n(wp_pin_n), .spi_do(spi_do), .spi_do_oe(spi_do_oe), .busy(busy),
    .four_wire_command_mode(four_wire_command_mode), .quad_pins_en(quad_pins_en),
    .pause_pin_en(pause_pin_en), .pin_clear_en(pin_clear_en), .range_prot_en(range_prot_en),
    .block_lock_init(block_lock_init), .drive_level(drive_level), .status_word(status_word));
  fsr_host u_fsr_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_di(spi_di), .spi_do(spi_do));

  // System clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Decoded outputs against the model
  task automatic ports();
    repeat (4) @(posedge clock);
    chk("word", status_word, m);
    chk("busy", busy, m[0]);
    chk("four_wire", four_wire_command_mode, fw);
    chk("quad", quad_pins_en, m[9]);
    chk("pause", pause_pin_en, !m[9] && !m[23]);
    chk("clear", pin_clear_en, !m[9] && m[23]);
    chk("range", range_prot_en, !m[18]);
    chk("locks", block_lock_init, m[18]);
    chk("drive", drive_level, m[22:21]);
    chk("out_enable", spi_do_oe, 1'b0);
  endtask

  // One instruction through the host, then the model follows it
  task automatic cmd(input logic [7:0] opc, input logic [7:0] dat = 8'h00, input int nb = 1);
    logic [7:0] rd;
    logic       ok;
    u_fsr_host.frame(opc, dat, nb, rd);
    ok = !m[0] || opc inside {8'h05, 8'h35, 8'h15, 8'h75};
    if (nb == 2 && opc == `FSR_OP_RDSR1) chk("rd_one", rd, m[7:0]);
    if (nb == 2 && opc == `FSR_OP_RDSR2) chk("rd_two", rd, m[15:8]);
    if (nb == 2 && opc == `FSR_OP_RDSR3) chk("rd_three", rd, m[23:16]);
    if (ok && opc inside {`FSR_OP_WRSR1, `FSR_OP_WRSR2, `FSR_OP_WRSR3}) begin
      if (m[1] && !m[8] && (!m[7] || wp_pin_n || m[9])) begin
        case (opc)
          `FSR_OP_WRSR1: m[7:2] = dat[7:2];
          `FSR_OP_WRSR2: begin
            m[8] = dat[0];
            m[9] = dat[1] | (fw & m[9]);
            m[13:11] = m[13:11] | dat[5:3];
            m[14] = dat[6];
          end
          default: begin
            m[18] = dat[2];
            m[23:21] = dat[7:5];
          end
        endcase
        m[1:0] = 2'b01;
      end
    end else if (ok) begin
      case (opc)
        `FSR_OP_WREN: m[1] = 1'b1;
        `FSR_OP_WRDI: m[1] = 1'b0;
        `FSR_OP_PP, `FSR_OP_SE: if (m[1]) m[1:0] = 2'b01;
        8'h38: fw = fw | m[9];
        `FSR_OP_SUSP: m[15] = 1'b1;
        `FSR_OP_RESU: m[15] = 1'b0;
        default: ;
      endcase
    end
    ports();
  endtask

  // Bounded wait for the internal operation, with its length checked
  task automatic wait_idle(input int lo);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clock);
      n++;
    end
    chk("busy_len", n >= lo && n <= 400, 1'b1);
    if (n >= 1000) give_verdict();
    m[0] = 1'b0;
    ports();
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    m = 24'h600000;
    fw = 1'b0;
    ports();
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    rst_n = 1'b0;
    wp_pin_n = 1'b1;
    void'($urandom(32'h108C));
    do_reset();
    // Latch set and cleared; write without latch refused
    cmd(`FSR_OP_WRSR1, 8'h1C, 2);
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_RDSR1, 8'h00, 2);
    cmd(`FSR_OP_WRDI);
    // Erase without latch ignored, with latch runs and drops the latch
    cmd(`FSR_OP_SE);
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_SE);
    wait_idle(350);
    $display("test latch done");
    // Random protect fields; enable ignored while busy
    repeat (4) begin
      r = 8'($urandom());
      cmd(`FSR_OP_WREN);
      cmd(`FSR_OP_WRSR1, r & 8'h7C, 2);
      cmd(`FSR_OP_WREN);
      wait_idle(100);
      cmd(`FSR_OP_RDSR1, 8'h00, 2);
    end
    $display("test protect fields done");
    // Hardware protection by the pin: low refuses, high accepts
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_WRSR1, 8'h80, 2);
    wait_idle(350);
    for (int w = 0; w < 2; w++) begin
      @(posedge clock);
      wp_pin_n <= w[0];
      cmd(`FSR_OP_WREN);
      cmd(`FSR_OP_WRSR1, 8'h1C, 2);
      wait_idle(0);
    end
    $display("test pin protection done");
    // Drive strength, scheme select and pin role for every code
    for (int i = 0; i < 8; i++) begin
      cmd(`FSR_OP_WREN);
      cmd(`FSR_OP_WRSR3, {i[2:0], 5'h00} | (i[0] ? 8'h04 : 8'h00), 2);
      cmd(`FSR_OP_RDSR1, 8'h00, 2);
      wait_idle(100);
      cmd(`FSR_OP_RDSR3, 8'h00, 2);
    end
    $display("test config three done");
    // Four-wire entry refused, then quad, complement, locks, suspend
    cmd(8'h38);
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_WRSR2, 8'h4A, 2);
    cmd(`FSR_OP_SUSP);
    wait_idle(0);
    cmd(`FSR_OP_RDSR2, 8'h00, 2);
    cmd(`FSR_OP_RESU);
    cmd(`FSR_OP_RDSR2, 8'h00, 2);
    cmd(8'h38);
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_WRSR2, 8'h30, 2);
    wait_idle(350);
    $display("test config two done");
    // Register lock blocks writes until reset
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_WRSR2, 8'h03, 2);
    wait_idle(350);
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_WRSR1, 8'h1C, 2);
    do_reset();
    cmd(`FSR_OP_RDSR2, 8'h00, 2);
    $display("test lock done");
    // Prefix bytes then a lock write: registers refuse every later write
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_PFX1);
    cmd(`FSR_OP_PFX2);
    cmd(`FSR_OP_WRSR2, 8'h01, 2);
    wait_idle(350);
    cmd(`FSR_OP_WREN);
    cmd(`FSR_OP_WRSR1, 8'h1C, 2);
    cmd(`FSR_OP_RDSR1, 8'h00, 2);
    $display("test prefix lock done");
    give_verdict();
  end
endmodule
